// ---- shared/emt_pkg.sv ----
// Constants and types shared by the emulator trace and measurement block.
`default_nettype none
package emt_pkg;

   // ----------------------------------------------------------------------
   // Clock and time base.
   // ----------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int MEAS_TICK_NS = 1000;
   localparam int CYC_PER_TICK = MEAS_TICK_NS / CLK_PERIOD_NS;
   localparam int PRESC_W = 4;
   localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(CYC_PER_TICK - 1);

   // ----------------------------------------------------------------------
   // Trace store and counter sizes.
   // ----------------------------------------------------------------------
   localparam int TRACE_DEPTH = 8192;
   localparam int TRACE_IDX_W = 13;
   localparam int MEAS_W = 31;
   localparam int DELAY_W = 16;

   // ----------------------------------------------------------------------
   // Register byte offsets on the AHB-Lite port.
   // ----------------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_RANGE_LO = 8'h08;
   localparam logic [7:0] OFS_RANGE_HI = 8'h0c;
   localparam logic [7:0] OFS_TRIG_PC = 8'h10;
   localparam logic [7:0] OFS_DELAY = 8'h14;
   localparam logic [7:0] OFS_TRACE_INDEX = 8'h18;
   localparam logic [7:0] OFS_TRACE_SEL = 8'h1c;
   localparam logic [7:0] OFS_TRACE_W0 = 8'h20;
   localparam logic [7:0] OFS_TRACE_W1 = 8'h24;
   localparam logic [7:0] OFS_TRACE_W2 = 8'h28;
   localparam logic [7:0] OFS_TRACE_W3 = 8'h2c;
   localparam logic [7:0] OFS_MEASURE = 8'h30;
   localparam logic [7:0] OFS_COV_SEL = 8'h34;
   localparam logic [7:0] OFS_COV_DATA = 8'h38;

   // ----------------------------------------------------------------------
   // Control register bit positions and target bus states.
   // ----------------------------------------------------------------------
   localparam int CB_RUN = 0;
   localparam int CB_STEP = 1;
   localparam int CB_STEP_OVER = 2;
   localparam int CB_FORCE_BRK = 3;
   localparam int CB_TMODE = 4;
   localparam int CB_MMODE = 6;
   localparam int CB_STEP_IE = 7;
   localparam int CB_COV_EN = 8;
   localparam int CB_COV_CLR = 9;
   localparam int CB_RNG_INV = 10;
   localparam logic [1:0] TS_T2 = 2'h1;
   localparam logic [1:0] TS_T4 = 2'h3;
   localparam logic [31:0] HSIZE_WORD = 32'h2;

   typedef enum logic [1:0] {EMT_STANDBY = 2'b00, EMT_RUN = 2'b01, EMT_STEP = 2'b11} emt_state_t;
   typedef enum logic [1:0] {EMT_TM_ALL = 2'b00, EMT_TM_RANGE = 2'b01, EMT_TM_DELAY = 2'b10} emt_tmode_t;

endpackage
`default_nettype wire

// ---- design/emt_trace_measure.sv ----
// Trace, trigger, coverage and run-time measurement logic of the emulator.
`timescale 1ns/1ps
`default_nettype none
module emt_trace_measure
   import emt_pkg::*;
#(
   parameter int PC_W = 16,
   parameter int INS_W = 13,
   parameter int DA_W = 16,
   parameter int DAT_W = 4,
   parameter int REG_W = 44
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [1:0] cpu_tstate,
   input wire logic [PC_W-1:0] cpu_pc,
   input wire logic [INS_W-1:0] cpu_instr,
   input wire logic [DA_W-1:0] cpu_daddr,
   input wire logic [DAT_W-1:0] cpu_data,
   input wire logic [REG_W-1:0] cpu_regs,
   input wire logic cpu_mem_rd,
   input wire logic cpu_mem_wr,
   input wire logic cpu_dummy_rd,
   input wire logic cpu_fetch,
   input wire logic cpu_instr_end,
   input wire logic cpu_vector_fetch,
   input wire logic cpu_halt,
   input wire logic cpu_in_sub,
   input wire logic interrupt_ack_n,
   input wire logic target_irq,
   input wire logic break_match,
   input wire logic reg_break_match,
   input wire logic trace_sense_in,
   output logic cpu_run,
   output logic cpu_irq,
   output logic periph_run,
   output logic trigger_pulse_out,
   output logic data_read_probe,
   output logic emulating
);

   // ----------------------------------------------------------------------
   // State record and memories.
   // ----------------------------------------------------------------------
   localparam int REC_W = REG_W + DAT_W + DA_W + INS_W + PC_W + 4;
   localparam int COV_W = PC_W - 5;
   localparam int COV_WORDS = 2 ** COV_W;

   typedef struct packed {
      emt_state_t state;
      logic step_over;
      logic cpu_run;
      logic cpu_irq;
      logic periph_run;
      logic trig_n;
      logic dread;
      logic hready;
      logic hresp;
      logic [31:0] hrdata;
      logic rd_wait;
      logic wr_pend;
      logic [7:0] addr_q;
      emt_tmode_t tmode;
      logic mmode;
      logic step_ie;
      logic cov_en;
      logic rng_inv;
      logic [PC_W-1:0] rng_lo;
      logic [PC_W-1:0] rng_hi;
      logic [PC_W-1:0] trig_pc;
      logic [DELAY_W-1:0] delay_cfg;
      logic [DELAY_W-1:0] delay_left;
      logic armed;
      logic done;
      logic [TRACE_IDX_W-1:0] wr_ptr;
      logic [TRACE_IDX_W-1:0] trace_sel;
      logic [TRACE_IDX_W:0] count;
      logic [MEAS_W-1:0] meas;
      logic [PRESC_W-1:0] presc;
      logic irq_pend;
      logic rb_pend;
      logic s1;
      logic s2;
      logic s3;
      logic sense;
      logic cov_clr;
      logic [COV_W-1:0] cov_ptr;
      logic [COV_W-1:0] cov_sel;
   } emt_st_t;

   emt_st_t st_reg;
   emt_st_t st_next;
   logic [REC_W-1:0] trace_mem [TRACE_DEPTH];
   logic [31:0] cov_mem [COV_WORDS];
   logic tr_we;
   logic cov_we;
   logic trig_now;
   logic [REC_W-1:0] rec_in;
   logic [TRACE_IDX_W-1:0] rd_idx;
   logic [127:0] rd_rec;

   // Saturating step of the measurement counter; it parks at its top value.
   function automatic logic [MEAS_W-1:0] sat_inc(input logic [MEAS_W-1:0] v);
      sat_inc = (&v) ? v : v + 1'b1;
   endfunction

   // ----------------------------------------------------------------------
   // Trace record assembly and read-back addressing.
   // ----------------------------------------------------------------------
   // The record is built from the cycle seen at T4, the sense level included.
   assign trig_now = (cpu_pc == st_reg.trig_pc);
   assign rec_in = {cpu_regs, cpu_data, cpu_daddr, cpu_instr, cpu_pc, cpu_mem_rd, cpu_mem_wr,
                    trig_now, st_reg.sense};
   // Once wrapped, index zero is the slot just after the newest record.
   assign rd_idx = (st_reg.count[TRACE_IDX_W]) ? st_reg.wr_ptr + st_reg.trace_sel : st_reg.trace_sel;
   assign rd_rec = 128'(trace_mem[rd_idx]);

   // Trace store write port; no reset, contents are only valid up to count.
   always_ff @(posedge hclk) begin
      if (tr_we) begin
         trace_mem[st_reg.wr_ptr] <= rec_in;
      end
   end

   // Coverage map; clearing sweeps one word per clock and blocks marking.
   always_ff @(posedge hclk) begin
      if (st_reg.cov_clr) begin
         cov_mem[st_reg.cov_ptr] <= 32'h0;
      end else if (cov_we) begin
         cov_mem[cpu_pc[PC_W-1:5]][cpu_pc[4:0]] <= 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // Next-state logic.
   // ----------------------------------------------------------------------
   always_comb begin
      logic bus_end;
      logic take;
      logic stop;
      logic int_ok;
      logic [31:0] rdv;
      st_next = st_reg;
      bus_end = st_reg.cpu_run && (cpu_tstate == TS_T4);
      take = 1'b0;
      stop = 1'b0;
      int_ok = 1'b0;
      rdv = 32'h0;
      tr_we = 1'b0;
      cov_we = 1'b0;

      // Three-stage sampler on the sense pin; a change counts once the last two stages agree.
      st_next.s1 = trace_sense_in;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      if (st_reg.s2 == st_reg.s3) begin
         st_next.sense = st_reg.s3;
      end

      // Trigger output goes low for the clock after T2, which is T3.
      st_next.trig_n = !(st_reg.cpu_run && (cpu_tstate == TS_T2) && trig_now);
      // The software-interrupt dummy read is offered to the data break logic as a read.
      st_next.dread = st_reg.cpu_run && (cpu_mem_rd || cpu_dummy_rd);

      // Requests are held in any state; an acknowledge clears, a new request wins.
      st_next.irq_pend = (st_reg.irq_pend && interrupt_ack_n) || target_irq;

      // Trace capture per bus cycle, only while emulating.
      if (bus_end && st_reg.state != EMT_STANDBY) begin
         case (st_reg.tmode)
            EMT_TM_ALL: take = 1'b1;
            EMT_TM_RANGE: take = ((cpu_pc >= st_reg.rng_lo) && (cpu_pc <= st_reg.rng_hi)) ^ st_reg.rng_inv;
            EMT_TM_DELAY: begin
               if (st_reg.armed && st_reg.delay_left == '0) begin
                  st_next.done = 1'b1;
               end else if (!st_reg.done) begin
                  take = 1'b1;
                  if (st_reg.armed) begin
                     st_next.delay_left = st_reg.delay_left - 1'b1;
                  end else if (trig_now) begin
                     st_next.armed = 1'b1;
                     st_next.delay_left = st_reg.delay_cfg;
                  end
               end
            end
            default: take = 1'b0;
         endcase
         cov_we = st_reg.cov_en && cpu_fetch && !st_reg.cov_clr;
      end
      tr_we = take;
      // Circular store: pointer wraps, record count saturates at the depth.
      if (tr_we) begin
         st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
         if (!st_reg.count[TRACE_IDX_W]) begin
            st_next.count = st_reg.count + 1'b1;
         end
      end

      // Measurement runs only out of standby, so a break freezes it.
      if (st_reg.state != EMT_STANDBY) begin
         if (st_reg.mmode) begin
            if (bus_end) begin
               st_next.meas = sat_inc(st_reg.meas);
            end
         end else if (st_reg.presc == PRESC_LAST) begin
            st_next.presc = '0;
            st_next.meas = sat_inc(st_reg.meas);
         end else begin
            st_next.presc = st_reg.presc + 1'b1;
         end
      end

      // Coverage clear sweep.
      if (st_reg.cov_clr) begin
         st_next.cov_ptr = st_reg.cov_ptr + 1'b1;
         if (&st_reg.cov_ptr) begin
            st_next.cov_clr = 1'b0;
         end
      end

      // Break handling: comparators stop at the cycle end, register breaks at an
      // instruction end with acknowledge released, so never inside the interrupt entry.
      if (st_reg.state != EMT_STANDBY) begin
         if (bus_end && break_match) begin
            stop = 1'b1;
         end
         if (bus_end && reg_break_match) begin
            st_next.rb_pend = 1'b1;
         end
         if (st_reg.rb_pend && bus_end && cpu_instr_end && interrupt_ack_n) begin
            stop = 1'b1;
         end
      end
      int_ok = (st_reg.state == EMT_RUN) ||
               ((st_reg.state == EMT_STEP) && (st_reg.step_ie || (st_reg.step_over && cpu_in_sub)));
      if (st_reg.state == EMT_STEP) begin
         if (bus_end && cpu_vector_fetch) begin
            stop = 1'b1;
         end else if (bus_end && cpu_instr_end && interrupt_ack_n && !(st_reg.step_over && cpu_in_sub)) begin
            stop = 1'b1;
         end
         if (!int_ok && cpu_halt) begin
            stop = 1'b1;
         end
         // A halt with interrupts allowed simply waits for a request or a forced break.
      end

      // AHB-Lite write data phase: commands act here, one word per transfer.
      if (st_reg.wr_pend) begin
         st_next.wr_pend = 1'b0;
         case (st_reg.addr_q)
            OFS_CTRL: begin
               st_next.tmode = emt_tmode_t'(hwdata[CB_TMODE +: 2]);
               st_next.mmode = hwdata[CB_MMODE];
               st_next.step_ie = hwdata[CB_STEP_IE];
               st_next.cov_en = hwdata[CB_COV_EN];
               st_next.rng_inv = hwdata[CB_RNG_INV];
               if (hwdata[CB_COV_CLR]) begin
                  st_next.cov_clr = 1'b1;
                  st_next.cov_ptr = '0;
               end
               if (st_reg.state == EMT_STANDBY) begin
                  if (hwdata[CB_RUN]) begin
                     st_next.state = EMT_RUN;
                     st_next.count = '0;
                     st_next.wr_ptr = '0;
                     st_next.armed = 1'b0;
                     st_next.done = 1'b0;
                     st_next.meas = '0;
                     st_next.presc = '0;
                  end else if (hwdata[CB_STEP] || hwdata[CB_STEP_OVER]) begin
                     st_next.state = EMT_STEP;
                     st_next.step_over = hwdata[CB_STEP_OVER];
                  end
               end else if (hwdata[CB_FORCE_BRK]) begin
                  stop = 1'b1;
               end
            end
            OFS_RANGE_LO: st_next.rng_lo = hwdata[PC_W-1:0];
            OFS_RANGE_HI: st_next.rng_hi = hwdata[PC_W-1:0];
            OFS_TRIG_PC: st_next.trig_pc = hwdata[PC_W-1:0];
            OFS_DELAY: st_next.delay_cfg = hwdata[DELAY_W-1:0];
            OFS_TRACE_SEL: st_next.trace_sel = hwdata[TRACE_IDX_W-1:0];
            OFS_COV_SEL: st_next.cov_sel = hwdata[COV_W-1:0];
            default: st_next.wr_pend = 1'b0;
         endcase
      end

      // A break returns to standby and drops the pending register break and the step-over flag.
      if (stop) begin
         st_next.state = EMT_STANDBY;
         st_next.rb_pend = 1'b0;
         st_next.step_over = 1'b0;
      end
      st_next.cpu_run = (st_next.state != EMT_STANDBY);
      st_next.periph_run = (st_next.state != EMT_STANDBY);
      st_next.cpu_irq = int_ok && !stop && st_next.cpu_run && st_next.irq_pend;

      // AHB-Lite read: one wait state so writes just before are visible.
      if (st_reg.rd_wait) begin
         case (st_reg.addr_q)
            OFS_CTRL: rdv = {21'h0, st_reg.rng_inv, 1'b0, st_reg.cov_en, st_reg.step_ie, st_reg.mmode,
                             st_reg.tmode, 4'h0};
            OFS_STATUS: rdv = {25'h0, st_reg.cov_clr, st_reg.irq_pend, st_reg.done, st_reg.armed,
                               st_reg.count[TRACE_IDX_W], st_reg.state};
            OFS_RANGE_LO: rdv = 32'(st_reg.rng_lo);
            OFS_RANGE_HI: rdv = 32'(st_reg.rng_hi);
            OFS_TRIG_PC: rdv = 32'(st_reg.trig_pc);
            OFS_DELAY: rdv = 32'(st_reg.delay_cfg);
            OFS_TRACE_INDEX: rdv = (st_reg.count == '0) ? 32'h0 : 32'(st_reg.count - 1'b1);
            OFS_TRACE_SEL: rdv = 32'(st_reg.trace_sel);
            OFS_TRACE_W0: rdv = rd_rec[31:0];
            OFS_TRACE_W1: rdv = rd_rec[63:32];
            OFS_TRACE_W2: rdv = rd_rec[95:64];
            OFS_TRACE_W3: rdv = rd_rec[127:96];
            OFS_MEASURE: rdv = 32'(st_reg.meas);
            OFS_COV_SEL: rdv = 32'(st_reg.cov_sel);
            OFS_COV_DATA: rdv = cov_mem[st_reg.cov_sel];
            default: rdv = 32'h0;
         endcase
         st_next.hrdata = rdv;
         st_next.rd_wait = 1'b0;
         st_next.hready = 1'b1;
      end

      // Address phase: only whole-word transfers are taken, others pass as no-ops.
      if (hsel && htrans[1] && hready && st_reg.hready && (32'(hsize) == HSIZE_WORD)) begin
         st_next.addr_q = haddr[7:0];
         if (hwrite) begin
            st_next.wr_pend = 1'b1;
         end else begin
            st_next.rd_wait = 1'b1;
            st_next.hready = 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // State register.
   // ----------------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_reg <= '0;
         st_reg.state <= EMT_STANDBY;
         st_reg.tmode <= EMT_TM_ALL;
         st_reg.trig_n <= 1'b1;
         st_reg.hready <= 1'b1;
         st_reg.s1 <= 1'b1;
         st_reg.s2 <= 1'b1;
         st_reg.s3 <= 1'b1;
         st_reg.sense <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs are taken straight from the state register.
   assign hrdata = st_reg.hrdata;
   assign hreadyout = st_reg.hready;
   assign hresp = st_reg.hresp;
   assign cpu_run = st_reg.cpu_run;
   assign cpu_irq = st_reg.cpu_irq;
   assign periph_run = st_reg.periph_run;
   assign trigger_pulse_out = st_reg.trig_n;
   assign data_read_probe = st_reg.dread;
   assign emulating = st_reg.cpu_run;

   // ----------------------------------------------------------------------
   // Assertions.
   // ----------------------------------------------------------------------
   default clocking emt_cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   chk_trig_in_t3: assert property (st_reg.cpu_run && cpu_tstate == TS_T2 && trig_now |=> !trigger_pulse_out)
      else $error("trigger pulse missing after T2 match");
   chk_trig_single: assert property (!trigger_pulse_out |=> trigger_pulse_out)
      else $error("trigger pulse longer than one clock");
   chk_index_cap: assert property (st_reg.count <= (TRACE_IDX_W+1)'(TRACE_DEPTH))
      else $error("trace count beyond depth");
   chk_ptr_wraps: assert property (tr_we && (&st_reg.wr_ptr) |=> st_reg.wr_ptr == '0)
      else $error("trace pointer did not wrap");
   chk_freeze_meas: assert property (st_reg.state == EMT_STANDBY && !st_reg.wr_pend |=> $stable(st_reg.meas))
      else $error("counter moved in standby");
   chk_standby_write: assert property (st_reg.state == EMT_STANDBY |-> !tr_we)
      else $error("trace written in standby");
   chk_periph_frozen: assert property (st_reg.state == EMT_STANDBY && !st_reg.wr_pend |=> !periph_run)
      else $error("peripheral ran in standby");
   chk_irq_standby: assert property (cpu_irq |-> $past(st_next.state) != EMT_STANDBY && st_reg.irq_pend)
      else $error("interrupt passed without a held request");
   chk_step_noint: assert property (st_reg.state == EMT_STEP && !st_reg.step_ie && !st_reg.step_over
                                    |=> !cpu_irq)
      else $error("interrupt passed in step with interrupts off");
   chk_cycle_count: assert property (st_reg.mmode && bus_end_a() && st_reg.state != EMT_STANDBY && !(&st_reg.meas)
                                     |=> st_reg.meas == $past(st_reg.meas) + 1'b1)
      else $error("bus cycle not counted");
   chk_range_only: assert property (tr_we && st_reg.tmode == EMT_TM_RANGE
                                    |-> ((cpu_pc >= st_reg.rng_lo && cpu_pc <= st_reg.rng_hi) ^ st_reg.rng_inv))
      else $error("out-of-range cycle traced");
   chk_delay_stop: assert property (st_reg.done |-> !tr_we)
      else $error("trace written after delay expired");
   chk_ack_holds: assert property (st_reg.state == EMT_RUN && !interrupt_ack_n && !break_match && !st_reg.wr_pend
                                   |=> st_reg.state == EMT_RUN)
      else $error("register break stopped during acknowledge");
   chk_halt_step: assert property (st_reg.state == EMT_STEP && !st_reg.step_ie && !st_reg.step_over && cpu_halt
                                   |=> st_reg.state == EMT_STANDBY ##1 !cpu_run)
      else $error("halt did not end the step");

   cov_wrap: cover property (tr_we && (&st_reg.wr_ptr) && st_reg.count[TRACE_IDX_W]);
   cov_delay_done: cover property (st_reg.armed ##[1:300] st_reg.done);
   cov_step_vector: cover property (st_reg.state == EMT_STEP && cpu_vector_fetch && cpu_tstate == TS_T4);
   cov_rb_after_ack: cover property (st_reg.rb_pend && !interrupt_ack_n ##[1:50] st_reg.state == EMT_STANDBY);

   // Helper for the cycle-count check.
   function automatic logic bus_end_a();
      bus_end_a = st_reg.cpu_run && (cpu_tstate == TS_T4);
   endfunction

endmodule // emt_trace_measure
`default_nettype wire

// ---- test/emt_cpu_model.sv ----
// Behavioural target CPU core that steps bus cycles while the emulator lets it run.
`timescale 1ns/1ps
`default_nettype none
module emt_cpu_model
   import emt_pkg::*;
#(
   parameter logic [15:0] BRK_PC = 16'h0009
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic cpu_run,
   output logic [1:0] cpu_tstate,
   output logic [15:0] cpu_pc,
   output logic break_match
);
   // States advance only while the core may run, so each run resumes in the state where the previous one stopped.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cpu_tstate <= 2'h0;
         cpu_pc <= 16'h0000;
      end else if (cpu_run) begin
         cpu_tstate <= cpu_tstate + 2'h1;
         if (cpu_tstate == TS_T4) begin
            cpu_pc <= cpu_pc + 16'h0001;
         end
      end
   end
   // The comparator hits only in the last state of the chosen cycle.
   assign break_match = cpu_run && (cpu_tstate == TS_T4) && (cpu_pc == BRK_PC);
endmodule // emt_cpu_model
`default_nettype wire

// ---- test/emulator_trace_and_measure_tb.sv ----
// Self-checking bench: one cycle-count run, then trace and counter read-back.
`timescale 1ns/1ps
`default_nettype none
module emulator_trace_and_measure_tb
   import emt_pkg::*;
;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp, irq_req = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [1:0] htrans = 2'h0, cpu_tstate;
   logic [2:0] hsize = 3'h2;
   logic [15:0] cpu_pc;
   logic break_match, cpu_run, cpu_irq, periph_run, trigger_pulse_out, data_read_probe, emulating;
   int bad_count = 0, n_compared = 0, pulses = 0, reads = 0;
   // Record fields follow the pc so every stored word is predictable; fetches are the pcs with bit 1 clear.
   emt_trace_measure dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .cpu_tstate, .cpu_pc, .cpu_instr(13'(cpu_pc)),
      .cpu_daddr(~cpu_pc), .cpu_data(cpu_pc[3:0]), .cpu_regs({28'h0, cpu_pc}), .cpu_mem_rd(cpu_pc[0]),
      .cpu_mem_wr(cpu_pc[1]), .cpu_dummy_rd(cpu_pc[2]), .cpu_fetch(~cpu_pc[1]), .cpu_instr_end(cpu_tstate == TS_T4),
      .cpu_vector_fetch(1'b0), .cpu_halt(1'b0), .cpu_in_sub(cpu_pc[3]), .interrupt_ack_n(~cpu_pc[4]),
      .target_irq(irq_req), .break_match, .reg_break_match(1'b0), .trace_sense_in(~cpu_pc[4]), .cpu_run,
      .cpu_irq, .periph_run, .trigger_pulse_out, .data_read_probe, .emulating);
   emt_cpu_model #(.BRK_PC(16'h0009)) cpu (.hclk, .hresetn, .cpu_run, .cpu_tstate, .cpu_pc, .break_match);
   // A 100 ns clock, and a counter of low trigger cycles.
   always #50 hclk = ~hclk;
   always @(posedge hclk) if (hresetn && !trigger_pulse_out) pulses <= pulses + 1;
   // Cycles in which the data break logic is offered a read, dummy reads included.
   always @(posedge hclk) if (data_read_probe) reads <= reads + 1;
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   // One word transfer; the address phase holds until hready is seen high.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic close_out;
      $display("Compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Long enough for the whole sequence several times over.
   initial begin
      #2000000;
      bad_count++;
      close_out;
   end
   // Main sequence: trigger at pc 5, break at pc 9, ten bus cycles in all.
   initial begin
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk("trigger idle", {31'h0, trigger_pulse_out}, 32'h00000001);
      xfer(1'b1, OFS_CTRL, 32'h00000200, rd);
      // A request raised in standby must be held while the coverage sweep runs.
      irq_req <= 1'b1;
      @(posedge hclk);
      irq_req <= 1'b0;
      repeat (2100) @(posedge hclk);
      xfer(1'b0, OFS_STATUS, 32'h0, rd);
      chk("held request", rd, 32'h00000020);
      xfer(1'b1, OFS_TRIG_PC, 32'h00000005, rd);
      xfer(1'b1, OFS_CTRL, 32'h00000141, rd);
      for (int i = 0; i < 300 && emulating !== 1'b1; i++) @(posedge hclk);
      @(posedge hclk);
      chk("irq on restart", {31'h0, cpu_irq}, 32'h00000001);
      chk("periph running", {31'h0, periph_run}, 32'h00000001);
      for (int i = 0; i < 300 && emulating !== 1'b0; i++) @(posedge hclk);
      // Extra idle cycles show whether the count stays frozen after the break.
      repeat (20) @(posedge hclk);
      chk("periph frozen", {31'h0, periph_run}, 32'h0);
      chk("irq off in standby", {31'h0, cpu_irq}, 32'h0);
      xfer(1'b0, OFS_MEASURE, 32'h0, rd);
      chk("cycle count", rd, 32'h0000000a);
      xfer(1'b0, OFS_TRACE_INDEX, 32'h0, rd);
      chk("trace index", rd, 32'h00000009);
      xfer(1'b1, OFS_TRACE_SEL, 32'h0, rd);
      xfer(1'b0, OFS_TRACE_W0, 32'h0, rd);
      chk("oldest record", rd, 32'h00000001);
      xfer(1'b1, OFS_TRACE_SEL, 32'h00000005, rd);
      xfer(1'b0, OFS_TRACE_W0, 32'h0, rd);
      chk("trigger record", rd, 32'h0050005b);
      chk("trigger pulses", 32'(pulses), 32'h00000001);
      xfer(1'b0, OFS_COV_DATA, 32'h0, rd);
      chk("coverage map", rd, 32'h00000333);
      chk("read probe", 32'(reads), 32'h0000001c);
      xfer(1'b0, 8'hfc, 32'h0, rd);
      chk("unmapped read", rd, 32'h0);
      chk("okay response", {31'h0, hresp}, 32'h0);
      close_out;
   end
endmodule // emulator_trace_and_measure_tb
`default_nettype wire
